//--- rdsbr_pkg.sv
// Shared constants for the decoder serial readout port and its host
package rdsbr_pkg;
  // Serial format
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_READ = 8'hA5;
  localparam logic [7:0] ADDR_WRITE = 8'hA4;
  localparam int CMD_W = 8;
  // Block store
  localparam int BUF_DEPTH = 24;
  localparam int BLK_W = 16;
  localparam int FLAG_W = 2;
  localparam int FULL_POS = 17;
  localparam int EMPTY_POS = 16;
  // Timing at the core clock
  localparam int CLK_KHZ = 125000;
  localparam int HOLDOFF_US = 265;
  localparam int HOLDOFF_CYC = HOLDOFF_US * CLK_KHZ / 1000;
  localparam int MIN_PHASE_NS = 750;
  localparam int HALF_CYC = (MIN_PHASE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int CE_MAX_MS = 20;
  // Values after reset
  localparam logic RST_CE = 1'b0;
  localparam logic RST_STB = 1'b0;
endpackage

//--- rdsbr_if.sv
// Link between decoder readout port and controlling host
`timescale 1ns/1ps
`default_nettype none
interface rdsbr_if;
  logic chip_enable;
  logic shift_strobe;
  logic serial_in_line;
  logic reply_out;
  logic reply_oe;
  logic reply_line;

  // Open-drain line with pull-up
  assign reply_line = reply_oe ? reply_out : 1'b1;

  modport dev  (input chip_enable, shift_strobe, serial_in_line, reply_line,
                output reply_out, reply_oe);
  modport host (output chip_enable, shift_strobe, serial_in_line,
                input reply_line);
endinterface
`default_nettype wire

//--- rdsbr_device.sv
// Decoder end: block store, request line and serial readout
// Behaviour
// [R1] Eight-bit address field opens every transfer; a longer field is accepted and decoded on its last eight bits
// [R2] No service until oscillator runs
// [R3] Buffer holds up to twenty-four blocks
// [R4] Stored block pulls request line low
// [R5] Line held high 265 us after readout
// [R6] Empty buffer keeps line high
// [R7] Remaining data: line low after holdoff
// [R8] High while unsynchronized, low at lock
// [R9] Readout within 480 ms avoids overwrite
// [R10] Readout within 20 ms after holdoff
// [R11] Several blocks readable per enable period
// [R12] Host keeps enable-high period under 20 ms
// [R13] Empty and full flags in read data
// [R14] No request: read data all zeros
// [R15] Host attributes shared-line requests by timing
// [R16] Host preferably gives dedicated enable lines
// [R17] Address with enable low, then data
`timescale 1ns/1ps
`default_nettype none
module rdsbr_device #(
  parameter int DEPTH          = rdsbr_pkg::BUF_DEPTH,
  parameter int DATA_W         = rdsbr_pkg::BLK_W,
  parameter int HOLDOFF_CYCLES = rdsbr_pkg::HOLDOFF_CYC
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Serial link
  rdsbr_if.dev                   link,
  // Decoder side
  input  wire logic              osc_running,
  input  wire logic              sync_reset,
  input  wire logic              sync_locked,
  input  wire logic              blk_valid,
  input  wire logic [DATA_W-1:0] blk_data,
  // Control bytes written by the host
  output logic                   cmd_valid,
  output logic [7:0]             cmd_byte,
  // Status
  output logic                   request_active
);
  localparam int OUT_W = DATA_W + rdsbr_pkg::FLAG_W;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int BW = $clog2(OUT_W);
  localparam int HW = $clog2(HOLDOFF_CYCLES + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [BW-1:0] LAST_BIT = BW'(OUT_W - 1);
  localparam logic [HW-1:0] HOLD_C = HW'(HOLDOFF_CYCLES);

  generate
    if (DEPTH < 2 || DATA_W < 1 || HOLDOFF_CYCLES < 1) begin : g_bad
      $error("rdsbr_device: unsupported parameters");
    end
  endgenerate

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_SKIP} rdsbr_dev_state_t;

  // Wrap-around pointer step
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Read word with flags, or zeros when nothing is served
  function automatic logic [OUT_W-1:0] make_word(input logic served, input logic [CW-1:0] cnt,
                                                 input logic [DATA_W-1:0] d);
    if (!served || cnt == '0) begin
      make_word = '0; // see [R14]
    end else begin
      make_word = {cnt == DEPTH_C, cnt == CW'(1), d}; // see [R13]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] ce_q;
  logic [2:0] stb_q;
  logic [1:0] din_q;
  logic       ce_rise;
  logic       ce_fall;
  logic       stb_rise;
  logic       stb_fall;

  // Two flops before use, third stage for edge finding
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ce_q  <= '0;
      stb_q <= '0;
      din_q <= '0;
    end else if (clk_en) begin
      ce_q  <= {ce_q[1:0], link.chip_enable};
      stb_q <= {stb_q[1:0], link.shift_strobe};
      din_q <= {din_q[0], link.serial_in_line};
    end
  end

  assign ce_rise  = ce_q[1] & ~ce_q[2];
  assign ce_fall  = ~ce_q[1] & ce_q[2];
  assign stb_rise = stb_q[1] & ~stb_q[2];
  assign stb_fall = ~stb_q[1] & stb_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Block store
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PW-1:0]     wr_ptr_reg;
  logic [PW-1:0]     rd_ptr_reg;
  logic [CW-1:0]     count_reg;
  logic              pop;
  logic              unsync_reg;
  logic [CW-1:0]     count_next;

  // Store array, written once per decoded block
  always_ff @(posedge mclk) begin
    if (clk_en && blk_valid && !sync_reset) begin
      mem[wr_ptr_reg] <= blk_data; // see [R3]
    end
  end

  // A full store drops its oldest block when a new one arrives
  always_comb begin
    count_next = count_reg;
    if (blk_valid && !pop && count_reg != DEPTH_C) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !blk_valid) begin
      count_next = count_reg - CW'(1);
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clk_en) begin
      if (sync_reset) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        if (blk_valid) begin
          wr_ptr_reg <= ptr_step(wr_ptr_reg);
        end
        if (pop || (blk_valid && count_reg == DEPTH_C)) begin
          rd_ptr_reg <= ptr_step(rd_ptr_reg); // see [R9] [R10]
        end
        count_reg <= count_next;
      end
    end
  end

  // Unsynchronized after a sync reset until lock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unsync_reg <= 1'b1;
    end else if (clk_en) begin
      if (sync_reset) begin
        unsync_reg <= 1'b1; // see [R8]
      end else if (sync_locked) begin
        unsync_reg <= 1'b0; // see [R8]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer control
  rdsbr_dev_state_t  state_reg;
  logic [7:0]        addr_reg;
  logic [3:0]        addr_cnt_reg;
  logic              served_reg;
  logic [OUT_W-1:0]  out_sh_reg;
  logic [BW-1:0]     bit_cnt_reg;
  logic [7:0]        in_sh_reg;
  logic [2:0]        in_cnt_reg;
  logic [HW-1:0]     hold_reg;
  logic              req;
  logic              last_out;

  assign req = osc_running && !unsync_reg && count_reg != '0 && hold_reg == '0;
  assign last_out = state_reg == ST_READ && stb_fall && bit_cnt_reg == LAST_BIT;
  assign pop = last_out && served_reg && count_reg != '0;

  // Address collection while enable is low, decode on its rise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      addr_reg     <= '0;
      addr_cnt_reg <= '0;
      served_reg   <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          if (ce_rise) begin
            addr_cnt_reg <= '0;
            if (!osc_running || addr_cnt_reg != 4'(rdsbr_pkg::ADDR_W)) begin
              state_reg <= ST_SKIP; // see [R1] [R2]
            end else if (addr_reg == rdsbr_pkg::ADDR_READ) begin
              state_reg  <= ST_READ; // see [R17]
              served_reg <= req;
            end else if (addr_reg == rdsbr_pkg::ADDR_WRITE) begin
              state_reg <= ST_WRITE;
            end else begin
              state_reg <= ST_SKIP;
            end
          end else if (stb_rise && !ce_q[1]) begin
            addr_reg <= {addr_reg[6:0], din_q[1]};
            if (addr_cnt_reg != 4'(rdsbr_pkg::ADDR_W)) begin
              addr_cnt_reg <= addr_cnt_reg + 4'(1);
            end
          end
        end
        ST_READ, ST_WRITE, ST_SKIP: begin
          if (ce_fall) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Read shifter: next bit after each falling strobe, blocks back to back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_reg  <= '0;
      bit_cnt_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == ST_IDLE && ce_rise) begin
        out_sh_reg  <= make_word(req, count_reg, mem[rd_ptr_reg]);
        bit_cnt_reg <= '0;
      end else if (last_out) begin
        out_sh_reg  <= make_word(served_reg, count_next, mem[ptr_step(rd_ptr_reg)]); // see [R11]
        bit_cnt_reg <= '0;
      end else if (state_reg == ST_READ && stb_fall) begin
        out_sh_reg  <= {out_sh_reg[OUT_W-2:0], 1'b0};
        bit_cnt_reg <= bit_cnt_reg + BW'(1);
      end
    end
  end

  // Write shifter: a byte per eight rising strobes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_sh_reg  <= '0;
      in_cnt_reg <= '0;
      cmd_valid  <= 1'b0;
      cmd_byte   <= '0;
    end else if (clk_en) begin
      cmd_valid <= 1'b0;
      if (state_reg != ST_WRITE) begin
        in_cnt_reg <= '0;
      end else if (stb_rise) begin
        in_sh_reg  <= {in_sh_reg[6:0], din_q[1]};
        in_cnt_reg <= in_cnt_reg + 3'(1);
        if (in_cnt_reg == 3'(7)) begin
          cmd_valid <= 1'b1;
          cmd_byte  <= {in_sh_reg[6:0], din_q[1]};
        end
      end
    end
  end

  // Holdoff after each readout once enable falls
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == ST_READ && ce_fall) begin
        hold_reg <= HOLD_C; // see [R5]
      end else if (hold_reg != '0) begin
        hold_reg <= hold_reg - HW'(1); // see [R7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain request and data line
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link.reply_oe  <= 1'b0;
      link.reply_out <= 1'b0;
      request_active <= 1'b0;
    end else if (clk_en) begin
      link.reply_out <= 1'b0;
      request_active <= req;
      if (state_reg == ST_READ) begin
        link.reply_oe <= ~out_sh_reg[OUT_W-1];
      end else begin
        link.reply_oe <= req; // see [R4] [R6] [R8]
      end
    end
  end
endmodule // rdsbr_device
`default_nettype wire

//--- rdsbr_host.sv
// Host end: drives enable, shift strobe and data, collects read words
`timescale 1ns/1ps
`default_nettype none
module rdsbr_host #(
  parameter int DATA_W     = rdsbr_pkg::BLK_W,
  parameter int HALF_CYC   = rdsbr_pkg::HALF_CYC,
  parameter int MAX_BLOCKS = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Serial link
  rdsbr_if.host                  link,
  // Requests
  input  wire logic              rd_start,
  input  wire logic [3:0]        rd_blocks,
  input  wire logic              wr_start,
  input  wire logic [7:0]        wr_byte,
  // Answers
  output logic                   busy,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_word,
  output logic                   rd_empty,
  output logic                   rd_full,
  output logic                   req_seen
);
  localparam int OUT_W = DATA_W + rdsbr_pkg::FLAG_W;
  localparam int TW = $clog2(HALF_CYC + 1);

  generate
    if (HALF_CYC < rdsbr_pkg::HALF_CYC || MAX_BLOCKS < 1 || MAX_BLOCKS > 15) begin : g_bad
      $error("rdsbr_host: unsupported parameters");
    end
  endgenerate

  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_SETUP, H_DATA, H_HOLD, H_END} rdsbr_host_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reply line synchroniser
  logic [1:0] line_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= 2'h3;
    end else if (clk_en) begin
      line_q <= {line_q[0], link.reply_line};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer, one step per half strobe period
  rdsbr_host_state_t state_reg;
  logic [TW-1:0]     tmr_reg;
  logic              ph_reg;
  logic [4:0]        bit_reg;
  logic [7:0]        tx_reg;
  logic [OUT_W-1:0]  rx_reg;
  logic              is_rd_reg;
  logic [3:0]        left_reg;
  logic              tick;

  assign tick = tmr_reg == TW'(HALF_CYC - 1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg           <= H_IDLE;
      tmr_reg             <= '0;
      ph_reg              <= 1'b0;
      bit_reg             <= '0;
      tx_reg              <= '0;
      rx_reg              <= '0;
      is_rd_reg           <= 1'b0;
      left_reg            <= '0;
      link.chip_enable    <= rdsbr_pkg::RST_CE;
      link.shift_strobe   <= rdsbr_pkg::RST_STB;
      link.serial_in_line <= 1'b0;
      busy                <= 1'b0;
      rd_valid            <= 1'b0;
      rd_word             <= '0;
      rd_empty            <= 1'b0;
      rd_full             <= 1'b0;
      req_seen            <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      req_seen <= state_reg == H_IDLE && !line_q[1];
      tmr_reg  <= (state_reg == H_IDLE || tick) ? '0 : tmr_reg + TW'(1);
      case (state_reg)
        H_IDLE: begin
          if (rd_start || wr_start) begin
            // Address shifts with enable low, MSB first
            is_rd_reg           <= rd_start;
            left_reg            <= (rd_blocks == '0) ? 4'(1) :
                                   (rd_blocks > 4'(MAX_BLOCKS)) ? 4'(MAX_BLOCKS) : rd_blocks;
            tx_reg              <= rd_start ? rdsbr_pkg::ADDR_READ : rdsbr_pkg::ADDR_WRITE;
            link.serial_in_line <= rd_start ? rdsbr_pkg::ADDR_READ[7] : rdsbr_pkg::ADDR_WRITE[7];
            bit_reg             <= '0;
            ph_reg              <= 1'b0;
            busy                <= 1'b1;
            state_reg           <= H_ADDR;
          end
        end
        H_ADDR: begin
          if (tick) begin
            ph_reg            <= ~ph_reg;
            link.shift_strobe <= ~ph_reg;
            if (ph_reg) begin
              bit_reg             <= bit_reg + 5'(1);
              tx_reg              <= {tx_reg[6:0], 1'b0};
              link.serial_in_line <= tx_reg[6];
              if (bit_reg == 5'(rdsbr_pkg::ADDR_W - 1)) begin
                link.chip_enable <= 1'b1;
                tx_reg           <= wr_byte;
                state_reg        <= H_SETUP;
              end
            end
          end
        end
        H_SETUP: begin
          if (tick) begin
            bit_reg             <= '0;
            link.serial_in_line <= is_rd_reg ? 1'b0 : tx_reg[7];
            state_reg           <= H_DATA;
          end
        end
        H_DATA: begin
          if (tick) begin
            ph_reg            <= ~ph_reg;
            link.shift_strobe <= ~ph_reg;
            if (!ph_reg) begin
              rx_reg <= {rx_reg[OUT_W-2:0], line_q[1]};
            end else begin
              bit_reg             <= bit_reg + 5'(1);
              tx_reg              <= {tx_reg[6:0], 1'b0};
              link.serial_in_line <= is_rd_reg ? 1'b0 : tx_reg[6];
              if (!is_rd_reg && bit_reg == 5'(rdsbr_pkg::CMD_W - 1)) begin
                state_reg <= H_HOLD;
              end else if (is_rd_reg && bit_reg == 5'(OUT_W - 1)) begin
                bit_reg  <= '0;
                rd_valid <= 1'b1;
                rd_word  <= rx_reg[DATA_W-1:0];
                rd_empty <= rx_reg[rdsbr_pkg::EMPTY_POS];
                rd_full  <= rx_reg[rdsbr_pkg::FULL_POS];
                left_reg <= left_reg - 4'(1);
                if (left_reg == 4'(1)) begin
                  state_reg <= H_HOLD; // see [R11] [R12]
                end
              end
            end
          end
        end
        H_HOLD: begin
          if (tick) begin
            link.chip_enable <= 1'b0;
            state_reg        <= H_END;
          end
        end
        H_END: begin
          if (tick) begin
            busy      <= 1'b0;
            state_reg <= H_IDLE;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end
endmodule // rdsbr_host
`default_nettype wire

//--- rdsbr_assertions.sv
// Concurrent checks on the readout link between the decoder and host ends
`timescale 1ns/1ps
`default_nettype none
module rdsbr_assertions #(
  parameter int HOLDOFF_CYCLES = rdsbr_pkg::HOLDOFF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link lines
  input wire logic chip_enable,
  input wire logic shift_strobe,
  input wire logic serial_in_line,
  input wire logic reply_out,
  input wire logic reply_oe,
  input wire logic reply_line
);
  localparam int CE_LIMIT = rdsbr_pkg::CE_MAX_MS * rdsbr_pkg::CLK_KHZ;
  localparam int MIN_HALF = rdsbr_pkg::HALF_CYC;
  logic        ce_reg;
  logic        strb_reg;
  logic [3:0]  addr_cnt;
  logic [15:0] hold_cnt;
  logic [7:0]  phase_cnt;
  logic [21:0] ce_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Previous levels and strobe rises counted while enable is low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_cnt <= 4'h0;
    end else if (chip_enable) begin
      addr_cnt <= 4'h0;
    end else if (shift_strobe && !strb_reg && addr_cnt != 4'hF) begin
      addr_cnt <= addr_cnt + 4'h1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ce_reg   <= 1'b0;
      strb_reg <= 1'b0;
    end else begin
      ce_reg   <= chip_enable;
      strb_reg <= shift_strobe;
    end
  end
  // Cycles since enable fell, since the strobe moved, and of enable high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt  <= 16'hFFFF;
      phase_cnt <= 8'hFF;
      ce_cnt    <= 22'h000000;
    end else begin
      hold_cnt  <= (ce_reg && !chip_enable) ? 16'h0001 : hold_cnt + {15'h0000, hold_cnt != 16'hFFFF};
      phase_cnt <= (shift_strobe != strb_reg) ? 8'h01 : phase_cnt + {7'h00, phase_cnt != 8'hFF};
      ce_cnt    <= !chip_enable ? 22'h000000 : ce_cnt + {21'h000000, ce_cnt != 22'h3FFFFF};
    end
  end
  ////////////////////////////////////////
  sequence strobe_held;
    shift_strobe && $past(shift_strobe);
  endsequence
  sequence bit_window;
    chip_enable && $past(chip_enable) ##0 strobe_held;
  endsequence
  a_drain_only_low: assert property (reply_oe |-> !reply_out && !reply_line)
    else $error("reply line driven other than low");
  a_addr_eight_bits: assert property ($rose(chip_enable) |-> addr_cnt == 4'h8)
    else $error("address field not eight bits");
  a_holdoff_high: assert property (!chip_enable && hold_cnt >= 16'h0008 && hold_cnt < HOLDOFF_CYCLES
    |-> !reply_oe)
    else $error("reply line low during holdoff");
  a_bit_steady: assert property (bit_window |-> $stable(reply_oe))
    else $error("read bit moved while strobe high");
  a_din_hold: assert property (strobe_held |-> $stable(serial_in_line))
    else $error("serial input moved while strobe high");
  a_ce_window: assert property (chip_enable |-> ce_cnt < CE_LIMIT)
    else $error("enable high too long");
  a_strobe_phase: assert property ($changed(shift_strobe) |-> phase_cnt >= MIN_HALF)
    else $error("strobe phase too short");
  a_ce_strobe_low: assert property ($changed(chip_enable) |-> !shift_strobe)
    else $error("enable moved with strobe high");
endmodule // rdsbr_assertions
`default_nettype wire

//--- test_rds_buffer_serial_readout.sv
// Bench: host and decoder ends joined over the link, plus a spare decoder
`timescale 1ns/1ps
`default_nettype none
module test_rds_buffer_serial_readout;
  localparam int HOLD  = 200;
  localparam int DEPTH = rdsbr_pkg::BUF_DEPTH;
  localparam int LIMIT = 100000;
  logic        mclk;
  logic        rst_n;
  logic        osc_running;
  logic        sync_reset;
  logic        sync_locked;
  logic        blk_valid;
  logic [15:0] blk_data;
  logic        rd_start;
  logic [3:0]  rd_blocks;
  logic        wr_start;
  logic [7:0]  wr_byte;
  logic        busy;
  logic        rd_valid;
  logic [15:0] rd_word;
  logic        rd_empty;
  logic        rd_full;
  logic        req_seen;
  logic        cmd_valid;
  logic [7:0]  cmd_byte;
  logic        request_active;
  logic [31:0] rng;
  logic [15:0] model[$];
  logic [17:0] got[$];
  logic [17:0] w;
  logic [7:0]  cmd_got;
  int          fails;
  int          n_tests;
  int          cyc;
  int          k;

  rdsbr_if link_if();
  rdsbr_if link2(); // Own enable and reply lines per decoder
  rdsbr_device #(.HOLDOFF_CYCLES(HOLD)) rdsbr_device_inst (
    .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .link(link_if), .osc_running(osc_running),
    .sync_reset(sync_reset), .sync_locked(sync_locked), .blk_valid(blk_valid),
    .blk_data(blk_data), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .request_active(request_active));
  // Spare decoder driven straight from the bench with malformed and well-formed transfers
  rdsbr_device #(.HOLDOFF_CYCLES(HOLD)) rdsbr_device_inst2 (
    .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .link(link2), .osc_running(osc_running),
    .sync_reset(sync_reset), .sync_locked(sync_locked), .blk_valid(blk_valid),
    .blk_data(blk_data), .cmd_valid(), .cmd_byte(), .request_active());
  rdsbr_host #(.HALF_CYC(rdsbr_pkg::HALF_CYC)) rdsbr_host_inst (
    .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .link(link_if), .rd_start(rd_start),
    .rd_blocks(rd_blocks), .wr_start(wr_start), .wr_byte(wr_byte), .busy(busy),
    .rd_valid(rd_valid), .rd_word(rd_word), .rd_empty(rd_empty), .rd_full(rd_full),
    .req_seen(req_seen));
  rdsbr_assertions #(.HOLDOFF_CYCLES(HOLD)) rdsbr_assertions_inst (
    .mclk(mclk), .rst_n(rst_n), .chip_enable(link_if.chip_enable),
    .shift_strobe(link_if.shift_strobe), .serial_in_line(link_if.serial_in_line),
    .reply_out(link_if.reply_out), .reply_oe(link_if.reply_oe),
    .reply_line(link_if.reply_line));

  // Core clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Collect read words and command bytes, cut a hang short
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) got.push_back({rd_full, rd_empty, rd_word});
    if (cmd_valid === 1'b1) cmd_got = cmd_byte;
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Read word: full flag if store held all blocks, empty flag on the last
  function automatic logic [17:0] exp_word(input int sz, input logic [15:0] d);
    return {sz == DEPTH, sz == 1, d};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // n random blocks into both stores; model drops the oldest when full
  task automatic push_rand(input int n);
    repeat (n) begin
      rng = xs(rng);
      @(posedge mclk);
      blk_valid <= 1'b1;
      blk_data  <= rng[15:0];
      @(posedge mclk);
      blk_valid <= 1'b0;
      if (model.size() == DEPTH) void'(model.pop_front());
      model.push_back(rng[15:0]);
    end
  endtask
  task automatic host_go(input logic rd, input int n);
    int t;
    t = 0;
    @(posedge mclk);
    rd_blocks <= 4'(n);
    rd_start  <= rd;
    wr_start  <= !rd;
    @(posedge mclk);
    rd_start <= 1'b0;
    wr_start <= 1'b0;
    @(posedge mclk);
    while (busy !== 1'b0 && t < 60000) begin
      @(posedge mclk);
      t++;
    end
  endtask
  task automatic host_rd(input int n);
    int          sz;
    logic [15:0] d;
    host_go(1'b1, n);
    check(got.size(), n);
    while (got.size() > 0) begin
      sz = model.size();
      d  = (sz > 0) ? model.pop_front() : 16'h0000;
      check(got.pop_front(), (sz > 0) ? exp_word(sz, d) : 18'h00000);
    end
    check(link_if.reply_line, 1'b1);
  endtask
  // Spare link: 160 ns strobe period, address bits MSB first, 18 read bits
  task automatic bb_xfer(input logic [8:0] a, input int nb);
    for (int i = nb - 1; i >= 0; i--) begin
      link2.serial_in_line <= a[i];
      wait_cyc(10);
      link2.shift_strobe <= 1'b1;
      wait_cyc(10);
      link2.shift_strobe <= 1'b0;
    end
    wait_cyc(10);
    link2.chip_enable    <= 1'b1;
    link2.serial_in_line <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      wait_cyc(10);
      link2.shift_strobe <= 1'b1;
      w = {w[16:0], link2.reply_line};
      wait_cyc(10);
      link2.shift_strobe <= 1'b0;
    end
    wait_cyc(10);
    link2.chip_enable <= 1'b0;
    wait_cyc(HOLD + 40);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    rng = 32'hF611;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    cmd_got = 'x;
    rst_n = 1'b0;
    osc_running = 1'b1;
    sync_reset = 1'b0;
    sync_locked = 1'b0;
    blk_valid = 1'b0;
    blk_data = 16'h0000;
    rd_start = 1'b0;
    rd_blocks = 4'h0;
    wr_start = 1'b0;
    wr_byte = 8'h00;
    link2.chip_enable = 1'b0;
    link2.shift_strobe = 1'b0;
    link2.serial_in_line = 1'b0;
    wait_cyc(2);
    rst_n <= 1'b1;
    push_rand(1);
    wait_cyc(10);
    check(link_if.reply_line, 1'b1);
    sync_locked <= 1'b1;
    wait_cyc(8);
    check(link_if.reply_line, 1'b0);
    check(link2.reply_line, 1'b0);
    bb_xfer(9'h0A5, 7);
    bb_xfer(9'h05A, 8);
    check(link2.reply_line, 1'b0);
    bb_xfer(9'h1A5, 9);
    check(w, exp_word(1, model[0]));
    bb_xfer(9'h0A5, 8);
    check(w, 18'h00000);
    host_rd(1);
    wait_cyc(HOLD);
    check(link_if.reply_line, 1'b1);
    for (int r = 0; r < 2; r++) begin
      rng = xs(rng);
      k = 2 + int'(rng[3:0]) % 3;
      push_rand(k);
      wait_cyc(8);
      check(link_if.reply_line, 1'b0);
      check(req_seen, 1'b1);
      host_rd(k - 1);
      wait_cyc(HOLD);
      check(link_if.reply_line, 1'b0);
      host_rd(1);
      wait_cyc(HOLD);
      check(link_if.reply_line, 1'b1);
      check(request_active, 1'b0);
    end
    push_rand(DEPTH + 1);
    host_rd(1);
    wait_cyc(HOLD);
    sync_locked <= 1'b0;
    sync_reset  <= 1'b1;
    wait_cyc(1);
    sync_reset <= 1'b0;
    model.delete();
    push_rand(1);
    wait_cyc(8);
    check(link_if.reply_line, 1'b1);
    sync_locked <= 1'b1;
    wait_cyc(8);
    check(link_if.reply_line, 1'b0);
    host_rd(1);
    wait_cyc(HOLD);
    push_rand(1);
    osc_running <= 1'b0;
    wait_cyc(8);
    check(link_if.reply_line, 1'b1);
    osc_running <= 1'b1;
    wait_cyc(8);
    check(link_if.reply_line, 1'b0);
    host_rd(1);
    wait_cyc(HOLD);
    host_rd(1);
    wait_cyc(HOLD);
    rng = xs(rng);
    wr_byte <= rng[7:0];
    host_go(1'b0, 1);
    wait_cyc(8);
    check(cmd_got, rng[7:0]);
    finish_test();
  end
endmodule // test_rds_buffer_serial_readout
`default_nettype wire
